// [pkg/supervisor_consts.svh]
// timing and sync constants for the supply supervisor
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define RESET_TIMEOUT_MS 200
`define WATCHDOG_TIMEOUT_MS 1600
`define CS_HOLD_US 18
`define RESET_TIMEOUT_CYC ((`RESET_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define WATCHDOG_CYC ((`WATCHDOG_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define CS_HOLD_CYC ((`CS_HOLD_US * 1000) / `CLK_PERIOD_NS)
`define CNT_W 32
`define SYNC_W 3
`endif

// [pkg/supervisor_pkg.sv]
// types for the supply supervisor
package supervisor_pkg;
   typedef enum logic [1:0]
   {
      GATE_PASS = 2'b00,
      GATE_HOLD = 2'b01,
      GATE_CLOSED = 2'b10
   } gate_state_t;
endpackage

// [core/pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   typedef struct packed
   {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] level;
   } sync_t;
   sync_t r;
   sync_t next_r;
   always_comb
   begin
      next_r = r;
      next_r.s1 = pin;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      // change counts once stages two and three agree
      for (int i = 0; i < WIDTH; i++)
      begin
         if (r.s2[i] == r.s3[i])
         begin
            next_r.level[i] = r.s3[i];
         end
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end
   assign level = r.level;
endmodule
`default_nettype wire

// [core/supply_supervisor_reset.sv]
// supply supervisor: reset stretch, watchdog, backup select, cs gate
// Notes on behaviour
// - reset_n is low while supply is below trip and stays low 200ms after.
// - a new below-trip event during the stretch restarts it from zero.
// - a toggle input stuck for 1.6s starts a 200ms reset.
// - a floating indication on the toggle input suppresses the watchdog timeout only.
// - reset_hi is always the inverse of reset_n, push-pull.
// - low_supply_warning_n goes low when supply is near the trip level.
// - backup path is chosen only below both trip and backup level.
// - main path is chosen whenever above either level.
// - the gated chip-select sits high while the gate is closed.
// - the watchdog clears on reset and on any toggle edge out of reset.
// - the watchdog stays cleared during reset and counts after release.
// - an active chip-select at reset passes up to 18us or until released.
// - once closed the gate stays high until reset ends and cs_in is low.
`timescale 1ns/100ps
`default_nettype none
`include "supervisor_consts.svh"
module supply_supervisor_reset #(
   parameter logic [`CNT_W-1:0] RESET_CYC = `RESET_TIMEOUT_CYC,
   parameter logic [`CNT_W-1:0] WDOG_CYC = `WATCHDOG_CYC,
   parameter logic [`CNT_W-1:0] HOLD_CYC = `CS_HOLD_CYC
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic below_reset_trip_level,
   input wire logic below_backup_level,
   input wire logic near_reset_trip_level,
   input wire logic watchdog_toggle_input,
   input wire logic watchdog_floating,
   input wire logic cs_in_n,
   output logic reset_n,
   output logic reset_hi,
   output logic low_supply_warning_n,
   output logic backup_supply_select,
   output logic cs_out_n
);
   import supervisor_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed
   {
      logic [`CNT_W-1:0] rst_cnt;
      logic [`CNT_W-1:0] wd_cnt;
      logic [`CNT_W-1:0] hold_cnt;
      logic wdi_prev;
      logic wd_fire;
      gate_state_t gate;
      logic reset_n;
      logic reset_hi;
      logic warn_n;
      logic backup;
      logic cs_out_n;
   } state_t;
   state_t r;
   state_t next_r;
   logic [5:0] sync_in;
   logic [5:0] sync_lv;
   logic s_below;
   logic s_bkup;
   logic s_near;
   logic s_wdi;
   logic s_float;
   logic s_cs_n;
   logic hold_rst;
   ////////////////////////////////////////////////////////////////////////
   // input synchroniser
   assign sync_in = {cs_in_n, watchdog_floating, watchdog_toggle_input,
                     near_reset_trip_level, below_backup_level,
                     below_reset_trip_level};
   pin_sync #(.WIDTH(6)) u_sync (
      .mclk(mclk),
      .nrst(nrst),
      .pin(sync_in),
      .level(sync_lv)
   );
   assign s_below = sync_lv[0];
   assign s_bkup = sync_lv[1];
   assign s_near = sync_lv[2];
   assign s_wdi = sync_lv[3];
   assign s_float = sync_lv[4];
   assign s_cs_n = sync_lv[5];
   // reset held while the cause stands or the stretch counter runs
   assign hold_rst = s_below || r.wd_fire || (r.rst_cnt != '0);
   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_r = r;
      next_r.wdi_prev = s_wdi;
      next_r.wd_fire = 1'b0;
      if (s_below || r.wd_fire)
      begin
         next_r.rst_cnt = RESET_CYC;
      end
      else if (r.rst_cnt != '0)
      begin
         next_r.rst_cnt = r.rst_cnt - 1'b1;
      end
      next_r.reset_n = !hold_rst;
      next_r.reset_hi = hold_rst;
      if (hold_rst || !r.reset_n || (s_wdi != r.wdi_prev) || s_float)
      begin
         next_r.wd_cnt = '0;
      end
      else if (r.wd_cnt >= WDOG_CYC - 1'b1)
      begin
         next_r.wd_fire = 1'b1;
         next_r.wd_cnt = '0;
      end
      else
      begin
         next_r.wd_cnt = r.wd_cnt + 1'b1;
      end
      next_r.warn_n = !(s_near || s_below);
      next_r.backup = s_below && s_bkup;
      case (r.gate)
         GATE_PASS:
         begin
            if (hold_rst)
            begin
               next_r.gate = s_cs_n ? GATE_CLOSED : GATE_HOLD;
               next_r.hold_cnt = HOLD_CYC;
            end
         end
         GATE_HOLD:
         begin
            next_r.hold_cnt = r.hold_cnt - 1'b1;
            if (s_cs_n || r.hold_cnt <= 1)
            begin
               next_r.gate = GATE_CLOSED;
            end
         end
         GATE_CLOSED:
         begin
            if (!hold_rst && !s_cs_n)
            begin
               next_r.gate = GATE_PASS;
            end
         end
         default:
         begin
            next_r.gate = GATE_CLOSED;
         end
      endcase
      next_r.cs_out_n = (next_r.gate == GATE_CLOSED) ? 1'b1 : s_cs_n;
   end
   always_ff @(posedge mclk)
   begin
      if (!nrst)
      begin
         r <= '0;
         r.gate <= GATE_CLOSED;
         r.reset_hi <= 1'b1;
         r.warn_n <= 1'b0;
         r.cs_out_n <= 1'b1;
         r.rst_cnt <= RESET_CYC;
      end
      else
      begin
         r <= next_r;
      end
   end
   assign reset_n = r.reset_n;
   assign reset_hi = r.reset_hi;
   assign low_supply_warning_n = r.warn_n;
   assign backup_supply_select = r.backup;
   assign cs_out_n = r.cs_out_n;
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   AST_RESET_WHILE_LOW: assert property
      (s_below |=> !reset_n) else $error("reset not low below trip");
   AST_STRETCH: assert property
      ($fell(s_below) |=> !reset_n [*8]) else $error("stretch too short");
   AST_TWIN: assert property
      (reset_hi == !reset_n) else $error("twin not inverse");
   AST_WD_FIRE: assert property
      (r.wd_fire |=> !reset_n) else $error("watchdog no reset");
   AST_FLOAT: assert property
      (s_float |=> !r.wd_fire) else $error("watchdog fired floating");
   AST_WD_CLEAR: assert property
      (!reset_n |=> r.wd_cnt == '0) else $error("watchdog ran in reset");
   AST_BACKUP: assert property
      (backup_supply_select |-> $past(s_below) && $past(s_bkup))
      else $error("backup chosen wrongly");
   AST_MAIN: assert property
      (!s_below |=> !backup_supply_select) else $error("main not chosen");
   AST_WARN: assert property
      (s_near |=> !low_supply_warning_n) else $error("no warning");
   AST_GATE_HIGH: assert property
      (r.gate == GATE_CLOSED |-> cs_out_n) else $error("cs passed closed");
   AST_GATE_STAYS: assert property
      (r.gate == GATE_CLOSED && s_below |=> cs_out_n)
      else $error("gate reopened in reset");
   AST_GATE_EARLY: assert property
      (r.gate == GATE_HOLD && s_cs_n |=> cs_out_n && r.gate == GATE_CLOSED)
      else $error("gate not closed on release");
   AST_WD_EDGE: assert property
      (reset_n && $changed(s_wdi) |=> r.wd_cnt == '0)
      else $error("toggle edge did not clear watchdog");
   CV_BROWNOUT: cover property ($rose(reset_n));
   CV_WDOG: cover property (r.wd_fire);
   CV_HOLD: cover property (r.gate == GATE_HOLD ##1 r.gate == GATE_CLOSED);
   CV_EARLY: cover property (r.gate == GATE_HOLD && s_cs_n);
endmodule
`default_nettype wire

// [sim/cpu_model.sv]
// far-side cpu model: watchdog toggling and ram chip-select
`timescale 1ns/100ps
`default_nettype none
module cpu_model (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic wd_en,
   input wire logic cs_req,
   output logic toggle,
   output logic cs_n
);
   logic [3:0] cnt = 4'h0;
   initial toggle = 1'b0;
   initial cs_n = 1'b1;
   // feeds the watchdog
   // toggles only out of reset, as firmware would
   always @(posedge mclk)
   begin
      cnt <= cnt + 4'h1;
      if (wd_en && reset_n && cnt == 4'hf)
         toggle <= ~toggle;
      cs_n <= ~cs_req;
   end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// testbench for the supply supervisor
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic below = 1'b0;
   logic bkup = 1'b0;
   logic near = 1'b0;
   logic flt = 1'b0;
   logic wd_en = 1'b1;
   logic cs_req = 1'b0;
   logic toggle, cs_n, reset_n, reset_hi, warn_n, bsel, cs_out_n;
   int num_errors = 0;
   int checked = 0;
   int n;
   always #5 mclk = ~mclk;
   cpu_model i_cpu (.mclk(mclk), .reset_n(reset_n), .wd_en(wd_en),
      .cs_req(cs_req), .toggle(toggle), .cs_n(cs_n));
   // short counts keep the run brief
   supply_supervisor_reset #(
      .RESET_CYC(32'h0000_0032),
      .WDOG_CYC(32'h0000_00c8),
      .HOLD_CYC(32'h0000_0014)
   ) i_dut (
      .mclk(mclk),
      .nrst(nrst),
      .below_reset_trip_level(below),
      .below_backup_level(bkup),
      .near_reset_trip_level(near),
      .watchdog_toggle_input(toggle),
      .watchdog_floating(flt),
      .cs_in_n(cs_n),
      .reset_n(reset_n),
      .reset_hi(reset_hi),
      .low_supply_warning_n(warn_n),
      .backup_supply_select(bsel),
      .cs_out_n(cs_out_n)
   );
   //////////////////////////////
   task automatic chk(input string what, input logic exp, input logic got);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value %s: expected %b, seen %b", what, exp, got);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task automatic wait_rst(input logic v, input int lim);
      n = 0;
      while (reset_n !== v && n < lim)
      begin
         @(negedge mclk);
         n++;
      end
   endtask
   task report_and_stop;
      if (num_errors == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   //////////////////////////////
   task brownout;
      below = 1'b1;
      near = 1'b1;
      wait_rst(0, 8);
      chk("reset_n", 1'b0, reset_n);
      chk("reset_hi", 1'b1, reset_hi);
      chk("warn_n", 1'b0, warn_n);
      below = 1'b0;
      cyc(25);
      below = 1'b1;
      cyc(5);
      below = 1'b0;
      cyc(45);
      chk("stretch", 1'b0, reset_n);
      wait_rst(1, 20);
      chk("reset_n", 1'b1, reset_n);
      chk("reset_hi", 1'b0, reset_hi);
      near = 1'b0;
      cyc(8);
      chk("warn_n", 1'b1, warn_n);
   endtask
   task backup;
      bkup = 1'b1;
      cyc(8);
      chk("bsel", 1'b0, bsel);
      chk("reset_n", 1'b1, reset_n);
      below = 1'b1;
      cyc(8);
      chk("bsel", 1'b1, bsel);
      bkup = 1'b0;
      cyc(8);
      chk("bsel", 1'b0, bsel);
      below = 1'b0;
      wait_rst(1, 70);
   endtask
   task wdog;
      wd_en = 1'b0;
      wait_rst(0, 300);
      chk("early", 1'b1, n > 150);
      chk("wdog", 1'b0, reset_n);
      wait_rst(1, 70);
      flt = 1'b1;
      cyc(400);
      chk("float", 1'b1, reset_n);
      flt = 1'b0;
      wd_en = 1'b1;
      // longer than the timeout, so only the toggles keep reset away
      cyc(400);
      chk("fed", 1'b1, reset_n);
   endtask
   task gate;
      cs_req = 1'b1;
      cyc(8);
      chk("cs_out_n", 1'b0, cs_out_n);
      below = 1'b1;
      cyc(8);
      chk("cs hold", 1'b0, cs_out_n);
      cyc(22);
      chk("cs cut", 1'b1, cs_out_n);
      cs_req = 1'b0;
      cyc(4);
      cs_req = 1'b1;
      cyc(8);
      chk("cs shut", 1'b1, cs_out_n);
      below = 1'b0;
      wait_rst(1, 70);
      cyc(8);
      chk("cs pass", 1'b0, cs_out_n);
   endtask
   task gate_early;
      below = 1'b1;
      cyc(6);
      // short release inside the hold window, then cs low again
      cs_req = 1'b0;
      cyc(2);
      cs_req = 1'b1;
      cyc(8);
      chk("cs early", 1'b1, cs_out_n);
      below = 1'b0;
      wait_rst(1, 70);
      cyc(8);
      chk("cs reopen", 1'b0, cs_out_n);
   endtask
   //////////////////////////////
   initial
   begin
      cyc(12);
      nrst = 1'b1;
      wait_rst(1, 80);
      chk("reset_n", 1'b1, reset_n);
      brownout();
      backup();
      wdog();
      gate();
      gate_early();
      report_and_stop();
   end
   initial
   begin
      #50000;
      num_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire
